// *** crbp_buffer.sv ***
// Configurable 25-bit 1:1 or 14-bit 1:2 registered buffer with parity
//
// How it works
// - Both selects low: 25-bit one-to-one buffer
// - Lo low, hi high: 1:2, Register A
// - Both high: 1:2, Register B inputs
// - Valid parity means even ones count
// - Mismatch pulls open-drain error output low
// - Deselected chip selects freeze data outputs
// - Partial parity out and in for cascading
// - Inputs captured on rising clock crossing
// - Hold only when both selects high
// - Error follows data outputs by one cycle
`default_nettype none
`include "crbp_defines.svh"
module crbp_buffer
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Configuration straps, asynchronous to core_clk
   input wire logic config_select_lo,
   input wire logic config_select_hi,
   // Command and address from the controller
   input wire crbp_pkg::crbp_word_type reg_data_in,
   input wire logic clock_enable_in,
   input wire logic termination_ctrl_in,
   input wire logic chip_select_a_n,
   input wire logic chip_select_b_n,
   // Parity and cascade
   input wire logic parity_bit_input,
   input wire logic partial_parity_input,
   output logic partial_parity_output,
   // Open-drain error pin
   input wire logic parity_error_n_in,
   output logic parity_error_n_o,
   output logic parity_error_n_oe,
   // Outputs to the module loads
   output crbp_pkg::crbp_word_type reg_data_out,
   output crbp_pkg::crbp_word_type reg_data_out_b,
   output crbp_pkg::crbp_pair_type clock_enable_out,
   output crbp_pkg::crbp_pair_type termination_ctrl_out,
   output crbp_pkg::crbp_pair_type chip_select_out,
   // Status
   output crbp_pkg::crbp_mode_type mode_status,
   output logic error_line_low
);
   import crbp_pkg::*;

   // ========================================================================
   // Decode helpers

   // Mode from the synchronised strap pair
   function automatic crbp_mode_type mode_of(input crbp_cfg_type cfg);
      crbp_mode_type m;
      m = crbp_mode_type'({cfg.hi, cfg.lo});
      return m;
   endfunction

   // Mode-independent inputs that take part in each mode
   function automatic crbp_word_type mask_of(input crbp_mode_type m);
      crbp_word_type r;
      case (m)
         CRBP_MODE_WIDE: r = `CRBP_MASK_WIDE;
         CRBP_MODE_REG_A: r = `CRBP_MASK_REG_A;
         CRBP_MODE_REG_B: r = `CRBP_MASK_REG_B;
         default: r = `CRBP_MASK_NONE;
      endcase
      return r;
   endfunction

   // True in either 1:2 mode
   function automatic logic is_dual(input crbp_mode_type m);
      return (m == CRBP_MODE_REG_A) || (m == CRBP_MODE_REG_B);
   endfunction

   // ========================================================================
   // Strap synchroniser
   // Straps are meant to be static, but a two-stage catch keeps a slow or
   // late strap from making a metastable mode decode.
   crbp_cfg_type cfg_meta_ff;
   crbp_cfg_type cfg_sync_ff;
   crbp_cfg_type nxt_cfg_meta;
   crbp_cfg_type nxt_cfg_sync;
   crbp_mode_type mode;

   always_comb
   begin
      nxt_cfg_meta.hi = config_select_hi;
      nxt_cfg_meta.lo = config_select_lo;
      nxt_cfg_sync = cfg_meta_ff;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         cfg_meta_ff <= `CRBP_RST_CFG;
         cfg_sync_ff <= `CRBP_RST_CFG;
      end
      else
      begin
         cfg_meta_ff <= nxt_cfg_meta;
         cfg_sync_ff <= nxt_cfg_sync;
      end
   end

   assign mode = mode_of(cfg_sync_ff);
   assign mode_status = mode;

   // ========================================================================
   // Input capture and output registers
   // All capture happens on the rising edge of core_clk, which stands for
   // the true-rising, complement-falling crossing of the differential pair.
   crbp_word_type word_ff;
   crbp_word_type nxt_word;
   logic sel_ff;
   logic nxt_sel;
   crbp_word_type out_a_ff;
   crbp_word_type nxt_out_a;
   crbp_word_type out_b_ff;
   crbp_word_type nxt_out_b;
   crbp_pair_type cke_ff;
   crbp_pair_type nxt_cke;
   crbp_pair_type odt_ff;
   crbp_pair_type nxt_odt;
   crbp_pair_type cs_ff;
   crbp_pair_type nxt_cs;
   logic selected;
   logic dual;
   crbp_word_type masked;

   always_comb
   begin
      dual = is_dual(mode);
      masked = reg_data_in & mask_of(mode);
      // Data outputs hold only when both selects are high
      selected = ~(chip_select_a_n & chip_select_b_n);
      nxt_word = masked;
      nxt_sel = selected;
      nxt_out_a = out_a_ff;
      nxt_out_b = out_b_ff;
      if (selected)
      begin
         nxt_out_a = masked;
         // B copy exists only in the 1:2 modes; unused outputs drive low
         nxt_out_b = dual ? masked : `CRBP_RST_WORD;
      end
      // Control copies never freeze: they track the inputs every edge
      nxt_cke.a = clock_enable_in;
      nxt_cke.b = dual & clock_enable_in;
      nxt_odt.a = termination_ctrl_in;
      nxt_odt.b = dual & termination_ctrl_in;
      nxt_cs.a = chip_select_a_n;
      nxt_cs.b = dual & chip_select_a_n;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         word_ff <= `CRBP_RST_WORD;
         sel_ff <= `CRBP_RST_BIT;
         out_a_ff <= `CRBP_RST_WORD;
         out_b_ff <= `CRBP_RST_WORD;
         cke_ff <= {`CRBP_RST_BIT, `CRBP_RST_BIT};
         odt_ff <= {`CRBP_RST_BIT, `CRBP_RST_BIT};
         cs_ff <= {`CRBP_RST_BIT, `CRBP_RST_BIT};
      end
      else
      begin
         word_ff <= nxt_word;
         sel_ff <= nxt_sel;
         out_a_ff <= nxt_out_a;
         out_b_ff <= nxt_out_b;
         cke_ff <= nxt_cke;
         odt_ff <= nxt_odt;
         cs_ff <= nxt_cs;
      end
   end

   assign reg_data_out = out_a_ff;
   assign reg_data_out_b = out_b_ff;
   assign clock_enable_out = cke_ff;
   assign termination_ctrl_out = odt_ff;
   assign chip_select_out = cs_ff;

   // ========================================================================
   // Parity check
   // Words taken while deselected are not checked, since the controller may
   // leave the bus undriven then and a false alarm would be raised.
   logic parity_err;

   crbp_parity u_parity
   (
      .core_clk(core_clk),
      .rst(rst),
      .word(word_ff),
      .word_selected(sel_ff),
      .parity_bit(parity_bit_input),
      .partial_in(partial_parity_input),
      .error(parity_err),
      .partial_out(partial_parity_output)
   );

   // Open-drain: only ever pull low, release otherwise
   assign parity_error_n_o = `CRBP_RST_BIT;
   assign parity_error_n_oe = parity_err;

   // ========================================================================
   // Error line monitor
   // The shared wire may be pulled by a cascaded partner too, so its level
   // is a pin from outside and is synchronised before use.
   logic line_meta_ff;
   logic nxt_line_meta;
   logic line_low_ff;
   logic nxt_line_low;

   always_comb
   begin
      nxt_line_meta = parity_error_n_in;
      nxt_line_low = ~line_meta_ff;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         line_meta_ff <= `CRBP_PIN_IDLE;
         line_low_ff <= `CRBP_RST_BIT;
      end
      else
      begin
         line_meta_ff <= nxt_line_meta;
         line_low_ff <= nxt_line_low;
      end
   end

   assign error_line_low = line_low_ff;

endmodule
`default_nettype wire

// *** crbp_buffer_chk.sv ***
// Port checker of the configurable registered buffer
`default_nettype none
`include "crbp_defines.svh"
module crbp_buffer_chk
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Controller side
   input wire crbp_pkg::crbp_word_type reg_data_in,
   input wire logic chip_select_a_n,
   input wire logic chip_select_b_n,
   input wire logic clock_enable_in,
   input wire logic parity_bit_input,
   input wire logic partial_parity_input,
   // Load side
   input wire logic partial_parity_output,
   input wire logic parity_error_n_o,
   input wire logic parity_error_n_oe,
   input wire crbp_pkg::crbp_word_type reg_data_out,
   input wire crbp_pkg::crbp_word_type reg_data_out_b,
   input wire crbp_pkg::crbp_pair_type clock_enable_out,
   input wire crbp_pkg::crbp_mode_type mode_status
);
   timeunit 1ns;
   timeprecision 1ps;
   import crbp_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ====
   // Helpers
   logic [1:0] calm_ff;
   logic [1:0] nxt_calm;
   crbp_mode_type mode_ff;
   crbp_word_type mw;
   logic sel;
   assign sel = !(chip_select_a_n && chip_select_b_n);
   assign mw = reg_data_in & (mode_status[1] ? (mode_status[0] ? `CRBP_MASK_REG_B :
      `CRBP_MASK_REG_A) : (mode_status[0] ? `CRBP_MASK_NONE : `CRBP_MASK_WIDE));
   // Calm count keeps history checks off reset and mode switches
   always_comb nxt_calm = (rst || mode_status != mode_ff) ? 2'h0 : calm_ff + {1'b0, !calm_ff[1]};
   always_ff @(posedge core_clk)
   begin
      calm_ff <= nxt_calm;
      mode_ff <= mode_status;
   end
   // ====
   // Assertions
   a_hold_deselected:
      assert property (!sel |=> $stable(reg_data_out) && $stable(reg_data_out_b))
      else $error("held outputs moved");
   a_wide_copy:
      assert property (calm_ff[1] && sel && mode_status == CRBP_MODE_WIDE
         |=> reg_data_out == $past(mw) && reg_data_out_b == 25'h0) else $error("wide copy");
   a_reg_a_pairs:
      assert property (calm_ff[1] && sel && mode_status == CRBP_MODE_REG_A
         |=> reg_data_out == $past(mw) && reg_data_out_b == reg_data_out) else $error("reg a");
   a_reg_b_pairs:
      assert property (calm_ff[1] && sel && mode_status == CRBP_MODE_REG_B
         |=> reg_data_out == $past(mw) && reg_data_out_b == reg_data_out) else $error("reg b");
   a_error_timing:
      assert property (calm_ff[1] |-> ##2 parity_error_n_oe == ($past(sel, 2) &&
         (^$past(mw, 2) ^ $past(parity_bit_input) ^ $past(partial_parity_input))))
      else $error("error pin");
   a_partial_out:
      assert property (calm_ff[1] && sel |-> ##2
         partial_parity_output == (^$past(mw, 2) ^ $past(parity_bit_input))) else $error("ppo");
   a_pin_low_only:
      assert property (parity_error_n_oe |-> parity_error_n_o == 1'b0) else $error("pin high");
   a_cke_not_held:
      assert property (calm_ff[1] |=> clock_enable_out.a == $past(clock_enable_in) &&
         clock_enable_out.b == ($past(mode_status[1]) && $past(clock_enable_in)))
      else $error("cke copy");
   c_hold: cover property (!sel ##1 sel);
   c_error: cover property (parity_error_n_oe);
   c_reg_b: cover property (sel && mode_status == CRBP_MODE_REG_B);
endmodule
bind crbp_buffer crbp_buffer_chk chk (.core_clk, .rst, .reg_data_in, .chip_select_a_n,
   .chip_select_b_n, .clock_enable_in, .parity_bit_input, .partial_parity_input,
   .partial_parity_output, .parity_error_n_o, .parity_error_n_oe, .reg_data_out,
   .reg_data_out_b, .clock_enable_out, .mode_status);
`default_nettype wire

// *** crbp_ctrl_model.sv ***
// Controller model: a word, then its even parity one cycle later
`default_nettype none
module crbp_ctrl_model
(
   // Clock and request
   input wire logic core_clk,
   input wire crbp_pkg::crbp_word_type mask,
   input wire crbp_pkg::crbp_word_type nxt_word,
   input wire logic nxt_flip,
   // Bus to the buffer
   output var crbp_pkg::crbp_word_type reg_data_in,
   output var logic parity_bit_input
);
   timeunit 1ns;
   timeprecision 1ps;
   crbp_pkg::crbp_word_type w;
   logic f;
   logic f_ff = 1'b0;
   // Sample at the edge, drive just after; a flip spoils one word only
   always @(posedge core_clk)
   begin
      w = nxt_word;
      f = nxt_flip;
      #1;
      parity_bit_input = ^(reg_data_in & mask) ^ f_ff;
      reg_data_in = w;
      f_ff = f;
   end
   initial
   begin
      reg_data_in = 25'h0;
      parity_bit_input = 1'b0;
   end
endmodule
`default_nettype wire

// *** crbp_defines.svh ***
// Constants for the configurable registered buffer with parity
`ifndef CRBP_DEFINES_SVH
`define CRBP_DEFINES_SVH

// ==========================================================================
// Widths
`define CRBP_DATA_W 25

// ==========================================================================
// Per-mode masks of the mode-independent data inputs (bit n-1 is input n)
`define CRBP_MASK_WIDE 25'h1ffffb6
`define CRBP_MASK_REG_A 25'h0003fb6
`define CRBP_MASK_REG_B 25'h0001bbf
`define CRBP_MASK_NONE 25'h0000000

// ==========================================================================
// Reset and idle values
`define CRBP_RST_WORD 25'h0000000
`define CRBP_RST_BIT 1'b0
`define CRBP_PIN_IDLE 1'b1
`define CRBP_RST_CFG 2'h0

`endif

// *** crbp_parity.sv ***
// Even parity checker and partial parity generator of the buffer
`default_nettype none
`include "crbp_defines.svh"
module crbp_parity
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Registered word and its parity, one cycle apart
   input wire crbp_pkg::crbp_word_type word,
   input wire logic word_selected,
   input wire logic parity_bit,
   input wire logic partial_in,
   // Results
   output logic error,
   output logic partial_out
);
   import crbp_pkg::*;

   logic error_ff;
   logic nxt_error;
   logic ppo_ff;
   logic nxt_ppo;
   logic word_odd;

   // ========================================================================
   // Parity arithmetic
   // The parity bit lands one cycle after its word, so the word is already
   // registered when the bit is sampled here.
   always_comb
   begin
      word_odd = ^word;
      nxt_ppo = word_odd ^ parity_bit;
      // Ones across word, parity bit and the cascade input must be even
      nxt_error = word_selected & (nxt_ppo ^ partial_in);
   end

   // Result registers, one cycle behind the data outputs
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         error_ff <= `CRBP_RST_BIT;
         ppo_ff <= `CRBP_RST_BIT;
      end
      else
      begin
         error_ff <= nxt_error;
         ppo_ff <= nxt_ppo;
      end
   end

   assign error = error_ff;
   assign partial_out = ppo_ff;

endmodule
`default_nettype wire

// *** crbp_pkg.sv ***
// Types shared by the configurable registered buffer with parity
`default_nettype none
`include "crbp_defines.svh"
package crbp_pkg;

   // ========================================================================
   // Operating modes, coded as {config_select_hi, config_select_lo}
   typedef enum logic [1:0] {
      CRBP_MODE_WIDE  = 2'b00,
      CRBP_MODE_RSVD  = 2'b01,
      CRBP_MODE_REG_A = 2'b10,
      CRBP_MODE_REG_B = 2'b11
   } crbp_mode_type;

   // ========================================================================
   // Output pair: copy A and copy B of one registered bit
   typedef struct packed {
      logic a;
      logic b;
   } crbp_pair_type;

   // Configuration strap pair
   typedef struct packed {
      logic hi;
      logic lo;
   } crbp_cfg_type;

   typedef logic [`CRBP_DATA_W-1:0] crbp_word_type;

endpackage
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench of the registered buffer with parity
`default_nettype none
`include "crbp_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import crbp_pkg::*;
   // ====
   // Signals
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   crbp_cfg_type cfg = 2'h0;
   crbp_word_type mask = `CRBP_MASK_WIDE;
   crbp_word_type nxt_word = 25'h0;
   logic nxt_flip = 1'b0;
   logic chip_select_a_n = 1'b1;
   logic chip_select_b_n = 1'b1;
   logic clock_enable_in = 1'b0;
   logic partial_parity_input = 1'b0;
   crbp_word_type reg_data_in, reg_data_out, reg_data_out_b;
   logic parity_bit_input, partial_parity_output, parity_error_n_o, parity_error_n_oe;
   logic error_line_low;
   wire parity_error_n_in;
   crbp_pair_type clock_enable_out, termination_ctrl_out, chip_select_out;
   crbp_mode_type mode_status;
   int error_cnt = 0;
   int comparisons = 0;
   int cycles = 0;
   // Pull-up: the wire is high unless the buffer pulls it
   assign parity_error_n_in = parity_error_n_oe ? parity_error_n_o : 1'b1;
   crbp_ctrl_model ctrl (.core_clk, .mask, .nxt_word, .nxt_flip, .reg_data_in,
      .parity_bit_input);
   crbp_buffer dut (.core_clk, .rst, .config_select_lo(cfg.lo), .config_select_hi(cfg.hi),
      .reg_data_in, .clock_enable_in, .termination_ctrl_in(~clock_enable_in),
      .chip_select_a_n, .chip_select_b_n, .parity_bit_input, .partial_parity_input,
      .partial_parity_output, .parity_error_n_in, .parity_error_n_o, .parity_error_n_oe,
      .reg_data_out, .reg_data_out_b, .clock_enable_out, .termination_ctrl_out,
      .chip_select_out, .mode_status, .error_line_low);
   initial forever #12.5 core_clk = ~core_clk;
   // ====
   // Shared tasks
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic check(input string what, input logic [24:0] seen, input logic [24:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      if (error_cnt == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Selects follow the word by a cycle, as the model delays it
   task automatic send(input crbp_word_type w, input logic f, input logic a_n, b_n);
      nxt_word = w;
      nxt_flip = f;
      step(1);
      nxt_flip = 1'b0;
      chip_select_a_n = a_n;
      chip_select_b_n = b_n;
      clock_enable_in = ~clock_enable_in;
      step(1);
   endtask
   // ====
   // Scenarios
   // Every strap code in turn: wide, reserved, Register A, Register B
   task automatic t_modes();
      crbp_word_type mk [4] = '{`CRBP_MASK_WIDE, `CRBP_MASK_NONE, `CRBP_MASK_REG_A,
         `CRBP_MASK_REG_B};
      for (int i = 0; i < 4; i++)
      begin
         cfg = crbp_cfg_type'(2'(i));
         mask = mk[i];
         step(4);
         check("mode", 25'(mode_status), 25'(cfg));
         send(25'h1ffffff, 1'b0, i == 2, 1'b0);
         check("q", reg_data_out, mk[i]);
         check("qb", reg_data_out_b, i >= 2 ? mk[i] : 25'h0);
         check("cke_b", 25'(clock_enable_out.b), 25'(i >= 2 && clock_enable_in));
         check("odt_b", 25'(termination_ctrl_out.b), 25'(i >= 2 && !clock_enable_in));
         check("cs_a", 25'(chip_select_out.a), 25'(i == 2));
         check("cs_b", 25'(chip_select_out.b), 25'(i == 2));
      end
   endtask
   // Deselected words neither reach the loads nor raise an error
   task automatic t_hold();
      send(25'h0, 1'b1, 1'b1, 1'b1);
      check("q", reg_data_out, `CRBP_MASK_REG_B);
      check("cke", 25'(clock_enable_out.a), 25'(clock_enable_in));
      check("odt", 25'(termination_ctrl_out.a), 25'(!clock_enable_in));
      check("cs", 25'(chip_select_out.a), 25'h1);
      step(1);
      check("oe", 25'(parity_error_n_oe), 25'h0);
      send(25'h0, 1'b0, 1'b1, 1'b0);
      check("q", reg_data_out, 25'h0);
   endtask
   // Good, spoiled, cascaded and unmasked-bit words
   task automatic t_parity();
      crbp_word_type w [4] = '{25'h6, 25'h2, 25'h6, 25'h1};
      logic f [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
      logic p [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
      cfg = 2'h0;
      mask = `CRBP_MASK_WIDE;
      step(4);
      for (int i = 0; i < 4; i++)
      begin
         send(w[i], f[i], 1'b0, 1'b0);
         check("oe", 25'(parity_error_n_oe), 25'h0);
         partial_parity_input = p[i];
         step(1);
         partial_parity_input = 1'b0;
         check("oe", 25'(parity_error_n_oe), 25'(f[i] ^ p[i]));
         check("ppo", 25'(partial_parity_output), 25'(f[i]));
         step(2);
         check("low", 25'(error_line_low), 25'(f[i] ^ p[i]));
      end
   endtask
   // Cut a hang short; the sequence needs about seventy cycles
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         error_cnt++;
         stop_test();
      end
   end
   initial
   begin
      step(16);
      check("oe", 25'(parity_error_n_oe), 25'h0);
      rst = 1'b0;
      step(3);
      t_modes();
      t_hold();
      t_parity();
      stop_test();
   end
endmodule
`default_nettype wire
